// [hdl/sewg_guard.sv]
// spi eeprom write guard: spi slave, protection checks, timed write cycle
// Function
// - sample instruction, address and data on rising serial clock while selected
// - count bits; suppress write if deselect not on whole octet
// - rising chip select after correct write command starts internal write
// - writes refused unless write-enable latch was set beforehand
// - unknown instruction deselects device until chip select cycles
// - block protection guards none, quarter, half or three quarters
// - write guard pin low rejects all write sequences
// - write guard pin falling during write aborts the cycle
// - clock count times out a write that runs too long
// - internal write completes within ten milliseconds
// - status register exposes write-in-progress, read in two bytes
`timescale 1ns/1ps
module sewg_guard #(
   parameter int AW           = 8,
   parameter int WRITE_CYCLES = sewg_pkg::WRITE_CYCLES,
   parameter int TMAX_CYCLES  = sewg_pkg::TMAX_CYCLES
) (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic spi_cs_n,
   input  wire logic spi_sck,
   input  wire logic spi_mosi,
   input  wire logic write_guard_pin,
   output logic      spi_miso,
   output logic      spi_miso_oe,
   output logic      write_busy,
   output logic      write_aborted
);
   // =========================================================
   // input synchronisers
   // =========================================================
   logic [1:0] cs_s_reg, sck_s_reg, mosi_s_reg, wg_s_reg;
   logic       cs_d_reg, sck_d_reg, wg_d_reg;

   // two flops per pin; second stage feeds logic, with a third flop on cs, sck and guard for edges
   always_ff @(posedge clock) begin
      if (reset) begin
         cs_s_reg   <= 2'h3;
         sck_s_reg  <= 2'h0;
         mosi_s_reg <= 2'h0;
         wg_s_reg   <= 2'h0;
         cs_d_reg   <= 1'b1;
         sck_d_reg  <= 1'b0;
         wg_d_reg   <= 1'b0;
      end else begin
         cs_s_reg   <= {cs_s_reg[0], spi_cs_n};
         sck_s_reg  <= {sck_s_reg[0], spi_sck};
         mosi_s_reg <= {mosi_s_reg[0], spi_mosi};
         wg_s_reg   <= {wg_s_reg[0], write_guard_pin};
         cs_d_reg   <= cs_s_reg[1];
         sck_d_reg  <= sck_s_reg[1];
         wg_d_reg   <= wg_s_reg[1];
      end
   end

   logic cs_act, sck_rise, sck_fall, cs_rise, wg_fall, wg_ok, mosi;
   assign cs_act   = ~cs_s_reg[1];
   assign sck_rise = sck_s_reg[1] & ~sck_d_reg;
   assign sck_fall = ~sck_s_reg[1] & sck_d_reg;
   assign cs_rise  = cs_s_reg[1] & ~cs_d_reg;
   assign wg_fall  = ~wg_s_reg[1] & wg_d_reg;
   assign wg_ok    = wg_s_reg[1];
   assign mosi     = mosi_s_reg[1];

   // =========================================================
   // frame shifter and bit counter
   // =========================================================
   logic [7:0]    shift_reg;
   logic [15:0]   nbits_reg;
   logic [7:0]    op_reg;
   logic [AW-1:0] addr_reg;
   logic [7:0]    data_reg;
   logic          dead_reg;     // deselected by bad opcode
   logic [7:0]    sh_next;
   logic          byte_done;

   assign sh_next   = {shift_reg[6:0], mosi};
   assign byte_done = sck_rise & (nbits_reg[2:0] == 3'h7);

   // capture on rising serial clock while selected
   always_ff @(posedge clock) begin
      if (reset || !cs_act) begin
         shift_reg <= 8'h00;
         nbits_reg <= 16'h0000;
         dead_reg  <= 1'b0;
      end else if (sck_rise && !dead_reg) begin
         shift_reg <= sh_next;
         nbits_reg <= nbits_reg + 16'h0001;
         if (byte_done && nbits_reg[15:3] == 13'h0000) begin
            unique case (sh_next)
               sewg_pkg::OP_WREN, sewg_pkg::OP_WRDI, sewg_pkg::OP_RDSR,
               sewg_pkg::OP_WRSR, sewg_pkg::OP_READ, sewg_pkg::OP_WRITE: ;
               default: dead_reg <= 1'b1;
            endcase
         end
      end
   end

   // latch opcode, address and first data byte
   always_ff @(posedge clock) begin
      if (reset) begin
         op_reg   <= 8'h00;
         addr_reg <= '0;
         data_reg <= 8'h00;
      end else if (byte_done && cs_act && !dead_reg) begin
         unique case (nbits_reg[15:3])
            13'h0000: op_reg   <= sh_next;
            13'h0001: addr_reg <= sh_next[AW-1:0];
            13'h0002: data_reg <= sh_next;
            default: ;
         endcase
      end
   end

   // =========================================================
   // status: latch, protection, write cycle
   // =========================================================
   typedef enum logic [1:0] {
      SEWG_IDLE = 2'b01,
      SEWG_BUSY = 2'b10
   } sewg_state_e;
   sewg_state_e   state_reg;
   logic          wel_reg;
   logic [1:0]    bp_reg = sewg_pkg::BP_RESET; // kept across reset as non-volatile image
   logic [1:0]    bp_pend_reg;
   logic [AW-1:0] wa_reg;       // write target frozen at cycle start
   logic [7:0]    wd_reg;
   logic          is_wrsr_reg;
   logic [31:0]   wcnt_reg, tcnt_reg;
   logic          mem_we;
   logic          octet_ok, prot_hit, frame_ok, good_op;
   logic [1:0]    top2;

   assign top2     = addr_reg[AW-1:AW-2];
   assign octet_ok = (nbits_reg[2:0] == 3'h0);
   // protected part is the upper quarter, half or three quarters
   assign prot_hit = (bp_reg != 2'h0) && ({1'b0, top2} >= (3'h4 - {1'b0, bp_reg}));
   assign frame_ok = ((op_reg == sewg_pkg::OP_WRITE) && (nbits_reg == 16'd24) && !prot_hit)
                  || ((op_reg == sewg_pkg::OP_WRSR) && (nbits_reg == 16'd16));
   assign good_op  = cs_rise && !dead_reg && octet_ok && wel_reg && wg_ok && frame_ok;

   // write cycle state machine
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg     <= SEWG_IDLE;
         wcnt_reg      <= 32'h0;
         tcnt_reg      <= 32'h0;
         write_aborted <= 1'b0;
         is_wrsr_reg   <= 1'b0;
      end else begin
         unique case (state_reg)
            SEWG_IDLE: begin
               wcnt_reg <= 32'h0;
               tcnt_reg <= 32'h0;
               if (good_op) begin
                  state_reg     <= SEWG_BUSY;
                  is_wrsr_reg   <= (op_reg == sewg_pkg::OP_WRSR);
                  write_aborted <= 1'b0;
               end
            end
            SEWG_BUSY: begin
               wcnt_reg <= wcnt_reg + 32'h1;
               tcnt_reg <= tcnt_reg + 32'h1;
               if (wg_fall || !wg_ok) begin
                  state_reg     <= SEWG_IDLE;
                  write_aborted <= 1'b1;
               end else if (tcnt_reg >= TMAX_CYCLES - 1) begin
                  state_reg     <= SEWG_IDLE;
                  write_aborted <= 1'b1;
               end else if (wcnt_reg >= WRITE_CYCLES - 1) begin
                  state_reg <= SEWG_IDLE;
               end
            end
         endcase
      end
   end

   // array and protection bits commit only at end of a full cycle
   assign mem_we = (state_reg == SEWG_BUSY) && !is_wrsr_reg && wg_ok && !wg_fall
                && (wcnt_reg >= WRITE_CYCLES - 1) && (tcnt_reg < TMAX_CYCLES - 1);

   // status byte of a 16-bit frame sits in the address slot (needs AW of at least 4);
   // target and data are frozen so a status poll during the cycle cannot move the write
   always_ff @(posedge clock) begin
      if (reset) begin
         bp_pend_reg <= sewg_pkg::BP_RESET;
         wa_reg      <= '0;
         wd_reg      <= 8'h00;
      end else if (good_op) begin
         bp_pend_reg <= addr_reg[sewg_pkg::BP_LSB +: 2];
         wa_reg      <= addr_reg;
         wd_reg      <= data_reg;
      end
   end

   // block protection is non-volatile; reset does not clear it
   always_ff @(posedge clock) begin
      if (state_reg == SEWG_BUSY && is_wrsr_reg && wg_ok && !wg_fall
          && wcnt_reg >= WRITE_CYCLES - 1 && tcnt_reg < TMAX_CYCLES - 1) begin
         bp_reg <= bp_pend_reg;
      end
   end

   // write-enable latch: set by enable op, cleared by disable or cycle start
   always_ff @(posedge clock) begin
      if (reset) begin
         wel_reg <= 1'b0;
      end else if (cs_rise && !dead_reg && octet_ok && nbits_reg == 16'd8
                   && op_reg == sewg_pkg::OP_WREN && state_reg == SEWG_IDLE) begin
         wel_reg <= 1'b1;
      end else if (good_op || (cs_rise && nbits_reg == 16'd8 && op_reg == sewg_pkg::OP_WRDI)) begin
         wel_reg <= 1'b0;
      end
   end

   // =========================================================
   // read path
   // =========================================================
   logic [7:0] rdata, status, obyte_reg;
   logic       busy;
   assign busy   = (state_reg == SEWG_BUSY);
   assign status = {4'h0, bp_reg, wel_reg, busy};

   sewg_mem #(.AW(AW)) u_mem (
      .clock (clock),
      .we    (mem_we),
      .waddr (wa_reg),
      .wdata (wd_reg),
      .raddr (addr_reg),
      .rdata (rdata)
   );

   // reply loads on the falling clock after the last command bit, so its msb is the first bit
   // out; loading on the rising edge would lose the msb to the shift at the following fall
   always_ff @(posedge clock) begin
      if (reset || !cs_act) begin
         obyte_reg <= 8'h00;
      end else if (sck_fall && nbits_reg == 16'd8 && op_reg == sewg_pkg::OP_RDSR) begin
         obyte_reg <= status;
      end else if (sck_fall && nbits_reg == 16'd16 && op_reg == sewg_pkg::OP_READ) begin
         obyte_reg <= rdata;
      end else if (sck_fall) begin
         obyte_reg <= {obyte_reg[6:0], 1'b0};
      end
   end

   // outputs straight from flops; miso drives only while selected and live
   always_ff @(posedge clock) begin
      if (reset) begin
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
         write_busy  <= 1'b0;
      end else begin
         spi_miso_oe <= cs_act && !dead_reg;
         spi_miso    <= obyte_reg[7];
         write_busy  <= busy;
      end
   end
endmodule : sewg_guard

// [hdl/sewg_pkg.sv]
// package of constants for the spi eeprom write guard
package sewg_pkg;
   // instruction codes
   localparam logic [7:0] OP_WREN  = 8'h06;
   localparam logic [7:0] OP_WRDI  = 8'h04;
   localparam logic [7:0] OP_RDSR  = 8'h05;
   localparam logic [7:0] OP_WRSR  = 8'h01;
   localparam logic [7:0] OP_READ  = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   // field positions
   localparam int         BP_LSB   = 2;
   localparam int         WEL_BIT  = 1;
   localparam int         WIP_BIT  = 0;
   // reset values
   localparam logic [1:0] BP_RESET = 2'h0;
   // timing
   localparam int         CLK_MHZ        = 200;
   localparam int         WRITE_TIME_US  = 5000;
   localparam int         WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
   localparam int         TMAX_TIME_US   = 10000;
   localparam int         TMAX_CYCLES    = TMAX_TIME_US * CLK_MHZ;
endpackage : sewg_pkg

// [hdl/sewg_mem.sv]
// byte memory array with registered read data
`timescale 1ns/1ps
module sewg_mem #(
   parameter int AW = 8
) (
   input  wire logic          clock,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   // write port and registered read port
   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : sewg_mem

// [verif/sewg_guard_properties.sv]
// port assertions for the write guard
`timescale 1ns/1ps
module sewg_guard_properties #(
   parameter int WRITE_CYCLES = 800,
   parameter int TMAX_CYCLES  = 1600
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   input wire logic write_guard_pin,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   input wire logic write_busy,
   input wire logic write_aborted
);
   // ======================================
   // busy length counter, zero while idle
   logic [31:0] busy_cnt;
   always_ff @(posedge clock) begin
      if (reset || !write_busy) busy_cnt <= 32'h0;
      else busy_cnt <= busy_cnt + 32'h1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // abort lands within the synchroniser latency
   sequence s_abort_end;
      ##[1:8] (!write_busy && write_aborted);
   endsequence
   sequence s_guard_drop;
      write_busy && $fell(write_guard_pin);
   endsequence
   // ======================================
   // checks
   a_start_on_deselect: assert property ($rose(write_busy) |-> spi_cs_n)
      else $error("write began while selected");
   a_guard_blocks: assert property (!write_guard_pin [*5] |-> !$rose(write_busy))
      else $error("write began with guard low");
   a_guard_aborts: assert property (s_guard_drop |-> s_abort_end)
      else $error("guard drop did not abort");
   a_busy_length: assert property ($fell(write_busy) && write_guard_pin
      |-> busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   a_timeout_bound: assert property (busy_cnt <= TMAX_CYCLES)
      else $error("write ran past time limit");
   a_abort_clears: assert property ($rose(write_busy) |-> ##[0:1] !write_aborted)
      else $error("abort flag kept at new write");
   a_abort_cause: assert property ($rose(write_aborted)
      |-> write_busy ##1 !write_busy)
      else $error("abort flag without a write");
   a_oe_deselected: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
      else $error("output driven while deselected");
endmodule : sewg_guard_properties

bind sewg_guard sewg_guard_properties #(.WRITE_CYCLES(WRITE_CYCLES), .TMAX_CYCLES(TMAX_CYCLES)) u_props (
   .clock(clock), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
   .write_guard_pin(write_guard_pin), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
   .write_busy(write_busy), .write_aborted(write_aborted));

// [verif/sewg_host.sv]
// host bus master model for the serial port
`timescale 1ns/1ps
module sewg_host (
   input  wire logic clock,
   output logic      spi_cs_n,
   output logic      spi_sck,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
   end
   // ======================================
   // n bits from d[23] down, 125 ns sck, idles low outside frames
   // every write frame is closed by raising select
   task automatic xfer(input logic [23:0] d, input int n, output logic [7:0] r, output logic o);
      logic [7:0] sh;
      sh = 8'h0;
      o = 1'b0;
      @(posedge clock) #1 spi_cs_n = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         spi_mosi = d[i];
         repeat (13) @(posedge clock);
         #1 sh = {sh[6:0], spi_miso};
         o = spi_miso_oe;
         spi_sck = 1'b1;
         repeat (12) @(posedge clock);
         #1 spi_sck = 1'b0;
      end
      repeat (13) @(posedge clock);
      #1 spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // released line must not look held
      r = sh;
      repeat (10) @(posedge clock);
   endtask : xfer
endmodule : sewg_host

// [verif/test_spi_eeprom_write_guard.sv]
// self-checking bench for the write guard
`timescale 1ns/1ps
module test_spi_eeprom_write_guard;
   logic       clock, reset, spi_cs_n, spi_sck, spi_mosi, write_guard_pin;
   logic       spi_miso, spi_miso_oe, write_busy, write_aborted, oe;
   logic [7:0] rd;
   int         error_cnt = 0;
   int         num_checks = 0;
   // write cycle shortened but long enough to poll status inside it
   sewg_guard #(.WRITE_CYCLES(800), .TMAX_CYCLES(1600)) u_dut (.clock(clock), .reset(reset),
      .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .write_guard_pin(write_guard_pin),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .write_busy(write_busy), .write_aborted(write_aborted));
   sewg_host u_host (.clock(clock), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ======================================
   // helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic cmd(input logic [23:0] d, input int n);
      u_host.xfer(d, n, rd, oe);
   endtask : cmd
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      cmd(24'h060000, 8);
      cmd({8'h02, a, v}, 24);
   endtask : wr
   task automatic wait_busy(input logic lvl);
      int i;
      for (i = 0; i < 2000 && write_busy !== lvl; i++) @(posedge clock);
      if (i == 2000) begin
         error_cnt++;
         end_sim();
      end
   endtask : wait_busy
   // ======================================
   // main sequence
   initial begin
      reset = 1'b1;
      write_guard_pin = 1'b0; // held low with reset until the bus settles
      repeat (5) @(posedge clock);
      #1 reset = 1'b0;
      write_guard_pin = 1'b1;
      repeat (4) @(posedge clock); // let the synchronisers flush before the first frame
      cmd(24'h050000, 16);
      chk(rd, 8'h00, "status");
      cmd(24'h0210a5, 24);
      chk({7'h0, write_busy}, 8'h0, "no latch");
      cmd(24'h060000, 8);
      cmd(24'h050000, 16);
      chk(rd, 8'h02, "latch");
      chk({7'h0, oe}, 8'h1, "oe");
      cmd(24'h0210a5, 20);
      chk({7'h0, write_busy}, 8'h0, "partial");
      #1 write_guard_pin = 1'b0;
      wr(8'h10, 8'ha5);
      chk({7'h0, write_busy}, 8'h0, "guarded");
      #1 write_guard_pin = 1'b1;
      wr(8'h10, 8'ha5);
      wait_busy(1'b1);
      cmd(24'h050000, 16);
      chk(rd, 8'h01, "wip");
      wait_busy(1'b0);
      cmd(24'h031000, 24);
      chk(rd, 8'ha5, "data");
      // guard dropped mid-cycle must abort and keep the old byte
      wr(8'h10, 8'h5a);
      wait_busy(1'b1);
      repeat (20) @(posedge clock);
      #1 write_guard_pin = 1'b0;
      wait_busy(1'b0);
      chk({7'h0, write_aborted}, 8'h1, "abort");
      #1 write_guard_pin = 1'b1;
      cmd(24'h031000, 24);
      chk(rd, 8'ha5, "kept");
      cmd(24'hff0500, 24);
      chk({7'h0, oe}, 8'h0, "unknown op");
      // each protect size: first protected address refused, one below accepted
      for (int b = 1; b < 4; b++) begin
         cmd(24'h060000, 8);
         cmd({8'h01, 4'h0, 2'(b), 2'h0, 8'h0}, 16);
         wait_busy(1'b0);
         cmd(24'h050000, 16);
         chk(rd, {4'h0, 2'(b), 2'h0}, "bp");
         wr(8'(256 - 64 * b), 8'h11);
         chk({7'h0, write_busy}, 8'h0, "protected");
         wr(8'(255 - 64 * b), 8'h22);
         chk({7'h0, write_busy}, 8'h1, "open");
         wait_busy(1'b0);
      end
      end_sim();
   end
endmodule : test_spi_eeprom_write_guard
